// *** baud_pkg.sv ***
// Contract
// - Async low speed: osc/(64*(div+1))
// - Async high speed: osc/(16*(div+1))
// - Sync master: osc/(4*(div+1))
// - Divisor unsigned, 0 through 255
// - Divisor write reloads the timer immediately
// - Receive pin majority of three samples
// - Free-running 8-bit timer set by divisor
// - Sync mode ignores high speed select
// - Sync rate applies only as internal clock master
package baud_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses, index times four)
   // ---------------------------------------------------------------
   localparam logic [7:0] RCV_CTRL_IDX = 8'h18;
   localparam logic [7:0] XMT_CTRL_IDX = 8'h98;
   localparam logic [7:0] DIVISOR_IDX = 8'h99;
   localparam logic [7:0] STATUS_IDX = 8'h9A;
   localparam logic [11:0] RCV_CTRL_ADDR = {2'h0, RCV_CTRL_IDX, 2'h0};
   localparam logic [11:0] XMT_CTRL_ADDR = {2'h0, XMT_CTRL_IDX, 2'h0};
   localparam logic [11:0] DIVISOR_ADDR = {2'h0, DIVISOR_IDX, 2'h0};
   localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};

   // ---------------------------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] RCV_CTRL_RESET = 8'h00;
   localparam logic [7:0] XMT_CTRL_RESET = 8'h02;
   localparam logic [7:0] DIVISOR_RESET = 8'h00;
   localparam logic [7:0] XMT_WRITE_MASK = 8'hF5;
   localparam int SPEN_BIT = 7;
   localparam int CLK_MASTER_BIT = 7;
   localparam int SYNC_BIT = 4;
   localparam int HIGH_SPEED_BIT = 2;
   localparam int SHIFT_EMPTY_BIT = 1;

   // ---------------------------------------------------------------
   // Prescale counts minus one (bit period = (prescale + 1) * (divisor + 1))
   // ---------------------------------------------------------------
   localparam logic [5:0] PRESCALE_LOW = 6'h3F;
   localparam logic [5:0] PRESCALE_HIGH = 6'h0F;
   localparam logic [5:0] PRESCALE_SYNC = 6'h03;

   // Rate modes of the generator
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_ASYNC_LOW = 2'b01,
      MODE_ASYNC_HIGH = 2'b11,
      MODE_SYNC = 2'b10
   } rate_mode_t;

endpackage : baud_pkg

// *** majority_sampler.sv ***
module majority_sampler (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Raw pin and sample strobe
   input wire logic pin_in,
   input wire logic sample_in,
   // Voted level
   output logic level_out
);

   // ---------------------------------------------------------------
   // Synchroniser and vote
   // ---------------------------------------------------------------
   logic sync1_reg; // First stage, read only by second
   logic sync2_reg;
   logic [2:0] hist_reg; // Last three samples

   // Two-flop synchroniser; idle line is high
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Shift a fresh sample in on each strobe
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         hist_reg <= 3'h7;
      end else if (sample_in) begin
         hist_reg <= {hist_reg[1:0], sync2_reg};
      end
   end

   // Two of three wins; rejects a single glitch sample
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         level_out <= 1'b1;
      end else begin
         level_out <= (hist_reg[0] & hist_reg[1]) | (hist_reg[1] & hist_reg[2]) |
                      (hist_reg[0] & hist_reg[2]);
      end
   end

endmodule : majority_sampler

// *** baud_rate_gen.sv ***
// Decided for this implementation: the APB interface to the registers.
module baud_rate_gen (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Serial logic status
   input wire logic shift_empty_in,
   // Receive pin
   input wire logic receive_input_pin_in,
   // Timing outputs and voted receive level
   output logic rate_tick_out,
   output logic bit_tick_out,
   output logic sample_tick_out,
   output logic rx_level_out
);

   // Overview:
   // Software sets the port enable, mode bits and divisor over the bus.
   // A down-counting timer reloads from the divisor and ticks once per
   // reload; a small prescale counter turns those ticks into bit ticks.
   // The same timer tick strobes the receive pin vote.
   // Limitation: framing, shifting and error flags live elsewhere; this
   // block only hands out timing and a cleaned receive level.
   // Hazard: a divisor write restarts both counters in the same edge, so
   // the first bit after it is never a stretched or shortened mix of old
   // and new rate.

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [7:0] rcv_ctrl_reg;   // Receive status and control
   logic [7:0] xmt_ctrl_reg;   // Transmit status and control
   logic [7:0] divisor_reg;    // Baud divisor, unsigned
   logic [7:0] timer_reg;      // Free-running rate timer
   logic [5:0] prescale_reg;   // Prescale stage counter
   logic [31:0] rdata_next;
   logic wr_en;
   logic rd_en;
   logic div_write;
   logic timer_term;
   logic prescale_term;
   logic [5:0] prescale_top;
   baud_pkg::rate_mode_t mode;

   // Address decode; map hit flag
   // Used only by the error response; the read mux decodes the
   // addresses in its own case list
   function automatic logic addr_hit(input logic [11:0] addr);
      addr_hit = (addr == baud_pkg::RCV_CTRL_ADDR) || (addr == baud_pkg::XMT_CTRL_ADDR) ||
                 (addr == baud_pkg::DIVISOR_ADDR) || (addr == baud_pkg::STATUS_ADDR);
   endfunction : addr_hit

   // ---------------------------------------------------------------
   // APB handshake
   // ---------------------------------------------------------------
   // Zero wait states: every access completes in its first access cycle
   assign pready_out = psel_in & penable_in;
   // Unmapped address answers with an error, no effect
   assign pslverr_out = psel_in & penable_in & ~addr_hit(paddr_in);
   assign wr_en = psel_in & penable_in & pwrite_in;
   assign rd_en = psel_in & penable_in & ~pwrite_in;
   assign div_write = wr_en && (paddr_in == baud_pkg::DIVISOR_ADDR);

   // Receive control register
   // Only the enable bit matters here; other bits are stored for the
   // receiver and read back unchanged
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rcv_ctrl_reg <= baud_pkg::RCV_CTRL_RESET;
      end else if (wr_en && paddr_in == baud_pkg::RCV_CTRL_ADDR) begin
         rcv_ctrl_reg <= pwdata_in[7:0];
      end
   end

   // Transmit control; shift-empty bit mirrors the shifter
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         xmt_ctrl_reg <= baud_pkg::XMT_CTRL_RESET;
      end else if (wr_en && paddr_in == baud_pkg::XMT_CTRL_ADDR) begin
         xmt_ctrl_reg <= pwdata_in[7:0] & baud_pkg::XMT_WRITE_MASK;
      end
   end

   // Divisor register; full 0..255 range accepted
   // Zero is legal and gives the fastest rate: one timer tick per clock
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         divisor_reg <= baud_pkg::DIVISOR_RESET;
      end else if (div_write) begin
         divisor_reg <= pwdata_in[7:0];
      end
   end

   // Read mux; combinational read data
   // Decoded straight from the address so a zero-wait read still sees
   // the value that stands at the access edge
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (paddr_in)
         baud_pkg::RCV_CTRL_ADDR: begin
            rdata_next = {24'h00_0000, rcv_ctrl_reg};
         end
         baud_pkg::XMT_CTRL_ADDR: begin
            rdata_next = {24'h00_0000, xmt_ctrl_reg[7:2], shift_empty_in, xmt_ctrl_reg[0]};
         end
         baud_pkg::DIVISOR_ADDR: begin
            rdata_next = {24'h00_0000, divisor_reg};
         end
         baud_pkg::STATUS_ADDR: begin
            // Live timer and prescale state for software
            rdata_next = {18'h0_0000, prescale_reg, timer_reg};
         end
         default: begin
            rdata_next = 32'h0000_0000;
         end
      endcase
   end

   // Read data stays on the bus only during the access
   assign prdata_out = rd_en ? rdata_next : 32'h0000_0000;

   // ---------------------------------------------------------------
   // Rate mode select
   // ---------------------------------------------------------------
   // Sync master ignores the high speed bit; sync slave or disabled
   // port stops the generator since the clock comes from outside
   always_comb begin
      if (!rcv_ctrl_reg[baud_pkg::SPEN_BIT]) begin
         mode = baud_pkg::MODE_OFF;
      end else if (xmt_ctrl_reg[baud_pkg::SYNC_BIT]) begin
         mode = xmt_ctrl_reg[baud_pkg::CLK_MASTER_BIT] ? baud_pkg::MODE_SYNC
                                                      : baud_pkg::MODE_OFF;
      end else if (xmt_ctrl_reg[baud_pkg::HIGH_SPEED_BIT]) begin
         mode = baud_pkg::MODE_ASYNC_HIGH;
      end else begin
         mode = baud_pkg::MODE_ASYNC_LOW;
      end
   end

   // Prescale length per mode (count minus one)
   always_comb begin
      case (mode)
         baud_pkg::MODE_ASYNC_LOW: begin
            prescale_top = baud_pkg::PRESCALE_LOW;
         end
         baud_pkg::MODE_ASYNC_HIGH: begin
            prescale_top = baud_pkg::PRESCALE_HIGH;
         end
         baud_pkg::MODE_SYNC: begin
            prescale_top = baud_pkg::PRESCALE_SYNC;
         end
         default: begin
            prescale_top = baud_pkg::PRESCALE_SYNC;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Rate timer
   // ---------------------------------------------------------------
   // Down-counter: period divisor+1 clocks
   // Counting down lets the reload compare against a constant zero
   // instead of the divisor, so a divisor change never skips a match.
   // While the generator is off the timer rests at its reload value,
   // which makes the first period after enabling a full one.
   assign timer_term = (timer_reg == 8'h00);

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         timer_reg <= 8'h00;
      end else if (div_write) begin
         // Restart at once so the new rate needs no old overflow
         timer_reg <= pwdata_in[7:0];
      end else if (mode == baud_pkg::MODE_OFF) begin
         timer_reg <= divisor_reg;
      end else if (timer_term) begin
         timer_reg <= divisor_reg;
      end else begin
         timer_reg <= timer_reg - 8'h01;
      end
   end

   // Single-cycle tick at terminal count
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rate_tick_out <= 1'b0;
      end else begin
         rate_tick_out <= timer_term && (mode != baud_pkg::MODE_OFF) && !div_write;
      end
   end

   // ---------------------------------------------------------------
   // Prescale stage
   // ---------------------------------------------------------------
   // Greater-or-equal rather than equal: a mode change to a shorter
   // prescale cannot leave the counter stranded above its new top.
   // Bit period is therefore (top + 1) timer ticks.
   assign prescale_term = (prescale_reg >= prescale_top);

   // Counts timer ticks; also restarted by a divisor write
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         prescale_reg <= 6'h00;
      end else if (div_write || mode == baud_pkg::MODE_OFF) begin
         prescale_reg <= 6'h00;
      end else if (rate_tick_out) begin
         prescale_reg <= prescale_term ? 6'h00 : prescale_reg + 6'h01;
      end
   end

   // Bit-period tick to the shift logic
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         bit_tick_out <= 1'b0;
      end else begin
         bit_tick_out <= rate_tick_out && prescale_term && !div_write &&
                         (mode != baud_pkg::MODE_OFF);
      end
   end

   // ---------------------------------------------------------------
   // Receive pin sampling
   // ---------------------------------------------------------------
   // One sample per timer tick; the last three feed the vote.
   // Trade-off: vote window follows the timer, not a fixed mid-bit slot
   assign sample_tick_out = rate_tick_out;

   // Pin is asynchronous; the sampler holds its own two-flop
   // synchroniser, so nothing here reads the raw pin.
   // Voted level resets high, the idle line level.
   majority_sampler u_sampler (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .pin_in(receive_input_pin_in),
      .sample_in(rate_tick_out),
      .level_out(rx_level_out)
   );

endmodule : baud_rate_gen

// *** shift_model.sv ***
module shift_model (
   // Clock, reset, tick from the generator and frame load
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic bit_tick_in,
   input wire logic load_in,
   // Shifter empty status back to the block
   output logic empty_out
);
   logic [3:0] bits_reg; // Bits still to shift out

   // Ten bit periods per frame; only counts on real bit ticks
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         bits_reg <= 4'h0;
      end else if (load_in) begin
         bits_reg <= 4'hA;
      end else if (bit_tick_in && bits_reg != 4'h0) begin
         bits_reg <= bits_reg - 4'h1;
      end
   end
   assign empty_out = (bits_reg == 4'h0);
endmodule : shift_model

// *** baud_rate_gen_properties.sv ***
module baud_rate_gen_properties (
   input wire logic sys_clk_in, rst_in, psel_in, penable_in, pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in, prdata_out,
   input wire logic pready_out, pslverr_out, shift_empty_in, receive_input_pin_in,
   input wire logic rate_tick_out, bit_tick_out, sample_tick_out, rx_level_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   logic acc; // Access phase
   logic hit; // Mapped address
   assign acc = psel_in && penable_in;
   assign hit = paddr_in inside {baud_pkg::RCV_CTRL_ADDR, baud_pkg::XMT_CTRL_ADDR,
      baud_pkg::DIVISOR_ADDR, baud_pkg::STATUS_ADDR};
   // Pin low over eight strobes, margin for the two-flop sync
   sequence low_run_s;
      (!receive_input_pin_in && rate_tick_out) [*8];
   endsequence
   zero_wait_a: assert property (acc |-> pready_out)
      else $error("no ready");
   idle_ready_a: assert property (!acc |-> !pready_out)
      else $error("stray ready");
   unmapped_error_a: assert property (acc |-> pslverr_out == !hit)
      else $error("bad slverr");
   upper_zero_a: assert property (acc && !pwrite_in |-> prdata_out[31:14] == 18'h00000 &&
      (paddr_in == baud_pkg::STATUS_ADDR || prdata_out[13:8] == 6'h00))
      else $error("upper bits");
   sample_rate_a: assert property (sample_tick_out == rate_tick_out)
      else $error("strobe");
   bit_after_rate_a: assert property (bit_tick_out |-> $past(rate_tick_out))
      else $error("bit tick");
   bit_single_a: assert property (bit_tick_out |=> !bit_tick_out [*2])
      else $error("long tick");
   rx_vote_low_a: assert property (low_run_s |=> !rx_level_out)
      else $error("vote");
   rx_idle_high_a: assert property ($fell(rst_in) |-> rx_level_out)
      else $error("rx reset");
endmodule : baud_rate_gen_properties

bind baud_rate_gen baud_rate_gen_properties u_props (.sys_clk_in, .rst_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
   .shift_empty_in, .receive_input_pin_in, .rate_tick_out, .bit_tick_out, .sample_tick_out,
   .rx_level_out);

// *** tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in, rst_in, psel_in, penable_in, pwrite_in, shift_empty_in;
   logic receive_input_pin_in, rate_tick_out, bit_tick_out, sample_tick_out;
   logic rx_level_out, pready_out, pslverr_out, load_in, pin;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, r;
   logic [7:0] d, x;
   logic [7:0] modes [4] = '{8'h00, 8'h04, 8'h90, 8'h94}; // Low, high, sync, sync+high
   int mismatches, n_compared, seed, n;

   baud_rate_gen u_dut (.sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .shift_empty_in,
      .receive_input_pin_in, .rate_tick_out, .bit_tick_out, .sample_tick_out, .rx_level_out);
   shift_model u_shift (.sys_clk_in, .rst_in, .bit_tick_in(bit_tick_out), .load_in,
      .empty_out(shift_empty_in));

   initial begin
      sys_clk_in = 1'h0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end

   // Expected bit period in clocks
   function automatic int bit_len(logic [7:0] m, logic [7:0] v);
      return (m[4] ? 4 : (m[2] ? 16 : 64)) * (int'(v) + 1);
   endfunction : bit_len

   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; idle edge after it so calls never collide
   task automatic apb(logic w, logic [11:0] a, logic [7:0] v);
      psel_in <= 1'h1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= {24'h000000, v};
      @(posedge sys_clk_in);
      penable_in <= 1'h1;
      do @(posedge sys_clk_in); while (pready_out !== 1'h1);
      r = prdata_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
      @(posedge sys_clk_in);
   endtask : apb

   task automatic rd(logic [11:0] a, logic [31:0] exp);
      apb(1'h0, a, 8'h00);
      chk(r, exp);
   endtask : rd

   // Edges until the chosen tick, less one
   task automatic cnt(logic w);
      n = 0;
      @(posedge sys_clk_in);
      while ((w ? bit_tick_out : rate_tick_out) !== 1'h1) begin
         @(posedge sys_clk_in);
         n++;
      end
   endtask : cnt

   task print_verdict;
      if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // Run needs about 10k cycles
   initial begin
      #400000;
      mismatches++;
      print_verdict();
   end

   initial begin
      seed = 32'h1A938D40;
      {rst_in, psel_in, penable_in, pwrite_in, load_in} = 5'h10;
      paddr_in = 12'h000;
      pwdata_in = 32'h00000000;
      receive_input_pin_in = 1'h1;
      repeat (12) @(posedge sys_clk_in);
      rst_in <= 1'h0;
      @(posedge sys_clk_in);
      // Reset values, refused place, read-only bits
      rd(baud_pkg::RCV_CTRL_ADDR, 32'h00000000);
      rd(baud_pkg::XMT_CTRL_ADDR, 32'h00000002);
      rd(baud_pkg::DIVISOR_ADDR, 32'h00000000);
      apb(1'h1, 12'h004, 8'hFF);
      rd(12'h004, 32'h00000000);
      apb(1'h1, baud_pkg::XMT_CTRL_ADDR, 8'hFF);
      rd(baud_pkg::XMT_CTRL_ADDR, 32'h000000F7);
      apb(1'h1, baud_pkg::RCV_CTRL_ADDR, 8'h80);
      // Every mode with zero, random and high divisors: 255 in sync, 15 in async
      foreach (modes[i]) for (int k = 0; k < 3; k++) begin
         x = modes[i];
         d = (k == 0) ? 8'h00 : (k == 1 ? 8'($random(seed)) & 8'h07 : (x[4] ? 8'hFF : 8'h0F));
         apb(1'h1, baud_pkg::XMT_CTRL_ADDR, x);
         apb(1'h1, baud_pkg::DIVISOR_ADDR, d);
         rd(baud_pkg::DIVISOR_ADDR, {24'h000000, d});
         cnt(1'h0);
         cnt(1'h0);
         chk(n, int'(d));
         cnt(1'h1);
         cnt(1'h1);
         chk(n + 1, bit_len(x, d));
      end
      // Sync slave: clock comes from outside, no ticks
      apb(1'h1, baud_pkg::XMT_CTRL_ADDR, 8'h10);
      n = 0;
      repeat (300) @(posedge sys_clk_in) if (rate_tick_out | bit_tick_out) n++;
      chk(n, 0);
      // Slow divisor replaced mid-period
      apb(1'h1, baud_pkg::XMT_CTRL_ADDR, 8'h00);
      apb(1'h1, baud_pkg::DIVISOR_ADDR, 8'hFF);
      repeat (100) @(posedge sys_clk_in);
      apb(1'h1, baud_pkg::DIVISOR_ADDR, 8'h00);
      cnt(1'h1);
      chk(n <= 70, 1'h1);
      // Random levels, then a one-cycle glitch
      apb(1'h1, baud_pkg::XMT_CTRL_ADDR, 8'h04);
      for (int k = 0; k < 9; k++) begin
         pin = (k == 8) ? 1'h1 : 1'($random(seed));
         receive_input_pin_in <= pin;
         repeat (12) @(posedge sys_clk_in);
         chk(rx_level_out, pin);
      end
      receive_input_pin_in <= 1'h0;
      @(posedge sys_clk_in);
      receive_input_pin_in <= 1'h1;
      repeat (12) @(posedge sys_clk_in);
      chk(rx_level_out, 1'h1);
      // Shifter busy then empty
      load_in <= 1'h1;
      @(posedge sys_clk_in);
      load_in <= 1'h0;
      rd(baud_pkg::XMT_CTRL_ADDR, 32'h00000004);
      repeat (200) @(posedge sys_clk_in);
      rd(baud_pkg::XMT_CTRL_ADDR, 32'h00000006);
      print_verdict();
   end
endmodule : tb
